// >>> dv/ccprs_partner.sv
`timescale 1ns/1ps
// Far port model: kind 0 none, 1 sink, 2 source
module ccprs_partner (
  input wire logic [1:0] kind,
  input wire logic line_sel,
  input wire logic [1:0] level,
  input wire logic vbus_on,
  input wire logic cc_pullup_en,
  input wire logic cc_pulldown_en,
  output logic bus_power_sense,
  output logic cc1_sink_seen,
  output logic cc2_sink_seen,
  output logic [1:0] cc1_adv_level,
  output logic [1:0] cc2_adv_level
);
  // A sink shows only against our pullup, a source's level only against our pulldown; its bus power shows regardless
  always_comb begin
    cc1_sink_seen = (kind == 2'h1) && !line_sel && cc_pullup_en;
    cc2_sink_seen = (kind == 2'h1) && line_sel && cc_pullup_en;
    cc1_adv_level = (kind == 2'h2 && !line_sel && cc_pulldown_en) ? level : ccprs_pkg::CUR_NONE;
    cc2_adv_level = (kind == 2'h2 && line_sel && cc_pulldown_en) ? level : ccprs_pkg::CUR_NONE;
    bus_power_sense = (kind == 2'h2) && vbus_on;
  end
endmodule : ccprs_partner

// >>> dv/ccprs_port_props.sv
`timescale 1ns/1ps
// Port checker, bound into the controller
module ccprs_port_props #(
  parameter longint unsigned FAULT_PULSE_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cable_overcurrent,
  input wire logic bus_power_sense,
  input wire logic cc_pullup_en,
  input wire logic [1:0] cc_pullup_level,
  input wire logic cc_pulldown_en,
  input wire logic sink_current_ind_a_o,
  input wire logic sink_current_ind_a_oe,
  input wire logic sink_current_ind_b_oe,
  input wire logic source_attach_n_oe,
  input wire logic orient_oe,
  input wire logic cable_supply_fault_n_o,
  input wire logic cable_supply_fault_n_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Run length of the fault pulse, checked when it ends
  logic [31:0] fault_len;
  logic [31:0] next_fault_len;
  always_comb begin
    next_fault_len = cable_supply_fault_n_oe ? fault_len + 32'h1 : 32'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_len <= 32'h0;
    end else begin
      fault_len <= next_fault_len;
    end
  end

  a_fault_width: assert property ($fell(cable_supply_fault_n_oe) |-> fault_len == FAULT_PULSE_CYCLES)
    else $error("fault pulse length wrong");
  a_fault_start: assert property ($rose(cable_overcurrent) && !cable_supply_fault_n_oe
    |-> ##[1:8] cable_supply_fault_n_oe)
    else $error("fault pulse did not start");
  a_pins_open_drain: assert property (!sink_current_ind_a_o && !cable_supply_fault_n_o)
    else $error("open drain pin driven high");
  a_ind_b_needs_a: assert property (sink_current_ind_b_oe |-> sink_current_ind_a_oe)
    else $error("indicator b low without a");
  a_ind_needs_power: assert property ($rose(sink_current_ind_a_oe) |-> $past(bus_power_sense, 4))
    else $error("sink attach without bus power");
  a_status_excl: assert property (!(source_attach_n_oe && sink_current_ind_a_oe))
    else $error("sink and source status together");
  a_attach_sourcing: assert property (source_attach_n_oe |-> $past(cc_pullup_en))
    else $error("attach shown while not sourcing");
  a_level_pullup: assert property (cc_pullup_en == (cc_pullup_level != ccprs_pkg::CUR_NONE))
    else $error("advertised level outside source role");
  a_role_excl: assert property (!(cc_pullup_en && cc_pulldown_en))
    else $error("pullup and pulldown together");
  a_orient_latched: assert property (source_attach_n_oe && $past(source_attach_n_oe) |-> $stable(orient_oe))
    else $error("orientation moved while attached");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
endmodule : ccprs_port_props

bind ccprs_port_ctrl ccprs_port_props #(.FAULT_PULSE_CYCLES(FAULT_PULSE_CYCLES)) i_ccprs_port_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .cable_overcurrent(cable_overcurrent), .bus_power_sense(bus_power_sense), .cc_pullup_en(cc_pullup_en),
  .cc_pullup_level(cc_pullup_level), .cc_pulldown_en(cc_pulldown_en), .sink_current_ind_a_o(sink_current_ind_a_o),
  .sink_current_ind_a_oe(sink_current_ind_a_oe), .sink_current_ind_b_oe(sink_current_ind_b_oe),
  .source_attach_n_oe(source_attach_n_oe), .orient_oe(orient_oe),
  .cable_supply_fault_n_o(cable_supply_fault_n_o), .cable_supply_fault_n_oe(cable_supply_fault_n_oe));

// >>> dv/test_cc_port_role_status_control.sv
`timescale 1ns/1ps
module test_cc_port_role_status_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_good, cable_overcurrent;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] role_strap, current_strap, cc1_adv_level, cc2_adv_level, cc_pullup_level, p_kind, p_level;
  logic bus_power_sense, cc1_sink_seen, cc2_sink_seen, cc_pullup_en, cc_pulldown_en, p_line, p_vbus, er;
  logic sink_current_ind_a_o, sink_current_ind_a_oe, sink_current_ind_b_o, sink_current_ind_b_oe;
  logic source_attach_n_o, source_attach_n_oe, orient_o, orient_oe, cable_supply_fault_n_o, cable_supply_fault_n_oe;
  int errors, checked;
  wire [5:0] pins = {sink_current_ind_a_oe, sink_current_ind_b_oe, source_attach_n_oe, orient_oe,
    cc_pullup_en, cc_pulldown_en};

  // ----------
  // Design and far port; short counts keep the run brief
  // ----------
  ccprs_port_ctrl #(.FAULT_PULSE_CYCLES(20), .DRP_HALF_CYCLES(16)) i_ccprs_port_ctrl (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_good(supply_good),
    .role_strap(role_strap), .current_strap(current_strap), .bus_power_sense(bus_power_sense),
    .cc1_sink_seen(cc1_sink_seen), .cc2_sink_seen(cc2_sink_seen), .cc1_adv_level(cc1_adv_level),
    .cc2_adv_level(cc2_adv_level), .cable_overcurrent(cable_overcurrent), .cc_pullup_en(cc_pullup_en),
    .cc_pullup_level(cc_pullup_level), .cc_pulldown_en(cc_pulldown_en),
    .sink_current_ind_a_o(sink_current_ind_a_o), .sink_current_ind_a_oe(sink_current_ind_a_oe),
    .sink_current_ind_b_o(sink_current_ind_b_o), .sink_current_ind_b_oe(sink_current_ind_b_oe),
    .source_attach_n_o(source_attach_n_o), .source_attach_n_oe(source_attach_n_oe), .orient_o(orient_o),
    .orient_oe(orient_oe), .cable_supply_fault_n_o(cable_supply_fault_n_o),
    .cable_supply_fault_n_oe(cable_supply_fault_n_oe));
  ccprs_partner i_ccprs_partner (.kind(p_kind), .line_sel(p_line), .level(p_level), .vbus_on(p_vbus),
    .cc_pullup_en(cc_pullup_en), .cc_pulldown_en(cc_pulldown_en), .bus_power_sense(bus_power_sense),
    .cc1_sink_seen(cc1_sink_seen), .cc2_sink_seen(cc2_sink_seen), .cc1_adv_level(cc1_adv_level),
    .cc2_adv_level(cc2_adv_level));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------
  // Shared tasks
  // ----------
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Supply rises after reset; strap captured then
  task do_reset(input logic [1:0] role);
    presetn <= 1'b0;
    supply_good <= 1'b0;
    role_strap <= role;
    current_strap <= ccprs_pkg::STRAP_LOW;
    p_kind <= 2'h0;
    p_vbus <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    supply_good <= 1'b1;
  endtask : do_reset

  task part(input logic [1:0] k, input logic ln, input logic [1:0] lv, input logic vb);
    p_kind <= k;
    p_line <= ln;
    p_level <= lv;
    p_vbus <= vb;
  endtask : part

  // Bounded wait for the pin set, judged mid-cycle
  task expect_pins(input string what, input logic [5:0] exp);
    int n;
    for (n = 0; n < 100 && pins !== exp; n++) @(negedge pclk);
    chk(what, {26'h0, exp}, {26'h0, pins});
    chk("pin drive", 32'h0, {29'h0, sink_current_ind_b_o, source_attach_n_o, orient_o});
    if (n == 100) give_verdict();
    @(posedge pclk);
  endtask : expect_pins

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the edge that samples pready high
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    if (n == 20) chk("apb ready", 32'h1, 32'h0);
    if (n == 20) give_verdict();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // ----------
  // Scenarios
  // ----------
  task test_sink;
    do_reset(ccprs_pkg::STRAP_LOW);
    expect_pins("sink idle", 6'h01);
    part(2'h2, 1'b0, ccprs_pkg::CUR_DEFAULT, 1'b0);
    repeat (30) @(negedge pclk);
    chk("sink no power", 32'h01, {26'h0, pins});
    @(posedge pclk);
    for (int i = 1; i < 4; i++) begin
      part(2'h2, 1'b0, 2'(i), 1'b1);
      expect_pins("sink level cc1", {i > 1, i > 2, 4'h5});
    end
    part(2'h2, 1'b0, ccprs_pkg::CUR_HIGH, 1'b0);
    expect_pins("sink power lost", 6'h01);
    part(2'h2, 1'b1, ccprs_pkg::CUR_HIGH, 1'b1);
    expect_pins("sink level cc2", 6'h31);
    $display("test sink done");
  endtask : test_sink

  task test_source;
    do_reset(ccprs_pkg::STRAP_HIGH);
    expect_pins("source idle", 6'h02);
    for (int i = 0; i < 4; i++) begin
      current_strap <= 2'(i);
      repeat (8) @(negedge pclk);
      chk("advertised level", (i == 1) ? 32'h2 : (i == 2) ? 32'h3 : 32'h1, {30'h0, cc_pullup_level});
      @(posedge pclk);
    end
    role_strap <= ccprs_pkg::STRAP_LOW;
    repeat (20) @(negedge pclk);
    chk("role kept", 32'h02, {26'h0, pins});
    @(posedge pclk);
    part(2'h1, 1'b1, 2'h0, 1'b0);
    expect_pins("source attach cc2", 6'h0A);
    part(2'h0, 1'b1, 2'h0, 1'b0);
    expect_pins("source detach", 6'h02);
    part(2'h1, 1'b0, 2'h0, 1'b0);
    expect_pins("source attach cc1", 6'h0E);
    $display("test source done");
  endtask : test_source

  task test_dual;
    int up;
    int dn;
    up = 0;
    dn = 0;
    do_reset(ccprs_pkg::STRAP_OPEN);
    repeat (100) begin
      @(negedge pclk);
      if (cc_pullup_en === 1'b1) up++;
      if (cc_pulldown_en === 1'b1) dn++;
    end
    chk("dual alternates", 32'h1, {31'h0, up >= 32 && dn >= 32});
    @(posedge pclk);
    part(2'h2, 1'b1, ccprs_pkg::CUR_MEDIUM, 1'b1);
    expect_pins("dual sink attach", 6'h21);
    $display("test dual done");
  endtask : test_dual

  task test_fault;
    int cnt;
    cnt = 0;
    do_reset(ccprs_pkg::STRAP_LOW);
    cable_overcurrent <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge pclk);
      if (cable_supply_fault_n_oe === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
    chk("fault pulse", 32'd20, cnt);
    @(posedge pclk);
    cable_overcurrent <= 1'b0;
    apb(1'b0, ccprs_pkg::REG_FAULT_CNT, 32'h0);
    chk("fault count", 32'h1, rd);
    apb(1'b1, ccprs_pkg::REG_FAULT_CNT, 32'h0);
    apb(1'b0, ccprs_pkg::REG_FAULT_CNT, 32'h0);
    chk("fault count cleared", 32'h0, rd);
    apb(1'b0, ccprs_pkg::REG_STATUS, 32'h0);
    chk("status role", {30'h0, ccprs_pkg::ROLE_SINK}, {30'h0, rd[4:3]});
    apb(1'b1, ccprs_pkg::REG_CTRL, 32'h1);
    apb(1'b0, ccprs_pkg::REG_CTRL, 32'h0);
    chk("ctrl readback", 32'h1, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    $display("test fault done");
  endtask : test_fault

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    cable_overcurrent = 1'b0;
    @(posedge pclk);
    test_sink();
    test_source();
    test_dual();
    test_fault();
    give_verdict();
  end
endmodule : test_cc_port_role_status_control

// >>> verilog/ccprs_pkg.sv
package ccprs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // Fault pulse length, plain default; tune per system
  localparam longint FAULT_PULSE_TIME_US = 1000;
  // Half period of the dual-role source/sink alternation
  localparam longint DRP_HALF_PERIOD_US = 35000;
  localparam int SYNC_WIDTH = 13;

  // ----------------------------------------------------------------
  // Four-level strap codes from the pad comparators
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [1:0] STRAP_OPEN = 2'h3;

  // Current advertisement / detection levels
  localparam logic [1:0] CUR_NONE = 2'h0;
  localparam logic [1:0] CUR_DEFAULT = 2'h1;
  localparam logic [1:0] CUR_MEDIUM = 2'h2;
  localparam logic [1:0] CUR_HIGH = 2'h3;

  typedef enum logic [1:0] {
    ROLE_SINK = 2'h0,
    ROLE_DUAL = 2'h1,
    ROLE_SOURCE = 2'h2
  } ccprs_role_e;

  // Gray order: wait, unattached sink, attached sink, ..., source side
  typedef enum logic [2:0] {
    ST_WAIT_SUPPLY = 3'h0,
    ST_UNATT_SNK = 3'h1,
    ST_ATT_SNK = 3'h3,
    ST_UNATT_SRC = 3'h2,
    ST_ATT_SRC = 3'h6
  } ccprs_state_e;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FAULT_CNT = 8'h08;
  localparam int CTRL_FORCE_DETACH = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ROLE_LSB = 3;
  localparam int STAT_ORIENT = 5;
  localparam int STAT_LEVEL_LSB = 6;
  localparam int STAT_FAULT = 8;
  localparam int STAT_ROLE_VALID = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

endpackage : ccprs_pkg

// >>> verilog/ccprs_port_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Source current advertisement comes from the current strap, used only when sourcing.
// - Current strap low or open gives default, mid gives 1.5A, high 3.0A.
// - Role strap is captured once the supply is reported active, then kept.
// - Role strap high is source only, open dual-role, low sink only.
// - Bus power sense qualifies every sink-role attach.
// - Cable supply over-current drives the fault output low for a fixed pulse.
// - Sink indicator A released for default, low for medium or high.
// - Sink indicator B released for default or medium, low for high.
// - Attach output goes low when a sink is attached while sourcing.
// - Orientation output released for plug position 2, low for position 1.
// - Dual-role port alternates source and sink until attachment settles.
// - Sink attach in sink-only and dual-role modes needs bus power.
module ccprs_port_ctrl #(
  parameter longint unsigned FAULT_PULSE_CYCLES =
    (ccprs_pkg::FAULT_PULSE_TIME_US * 1000000) / ccprs_pkg::CLK_PERIOD_PS,
  parameter longint unsigned DRP_HALF_CYCLES =
    (ccprs_pkg::DRP_HALF_PERIOD_US * 1000000) / ccprs_pkg::CLK_PERIOD_PS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_good,
  input wire logic [1:0] role_strap,
  input wire logic [1:0] current_strap,
  input wire logic bus_power_sense,
  input wire logic cc1_sink_seen,
  input wire logic cc2_sink_seen,
  input wire logic [1:0] cc1_adv_level,
  input wire logic [1:0] cc2_adv_level,
  input wire logic cable_overcurrent,
  output logic cc_pullup_en,
  output logic [1:0] cc_pullup_level,
  output logic cc_pulldown_en,
  output logic sink_current_ind_a_o,
  output logic sink_current_ind_a_oe,
  output logic sink_current_ind_b_o,
  output logic sink_current_ind_b_oe,
  output logic source_attach_n_o,
  output logic source_attach_n_oe,
  output logic orient_o,
  output logic orient_oe,
  output logic cable_supply_fault_n_o,
  output logic cable_supply_fault_n_oe
);

  localparam int TW = $clog2(DRP_HALF_CYCLES + 1);
  localparam logic [TW-1:0] TOGGLE_LAST = TW'(DRP_HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [ccprs_pkg::SYNC_WIDTH-1:0] raw_in;
  logic [ccprs_pkg::SYNC_WIDTH-1:0] syn;
  logic s_supply;
  logic [1:0] s_role;
  logic [1:0] s_cur;
  logic s_vbus;
  logic s_rd1;
  logic s_rd2;
  logic [1:0] s_adv1;
  logic [1:0] s_adv2;
  logic s_oc;

  assign raw_in = {supply_good, role_strap, current_strap, bus_power_sense, cc1_sink_seen,
                   cc2_sink_seen, cc1_adv_level, cc2_adv_level, cable_overcurrent};
  assign {s_supply, s_role, s_cur, s_vbus, s_rd1, s_rd2, s_adv1, s_adv2, s_oc} = syn;

  ccprs_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  ccprs_pkg::ccprs_state_e state;
  ccprs_pkg::ccprs_state_e next_state;
  ccprs_pkg::ccprs_role_e role;
  ccprs_pkg::ccprs_role_e next_role;
  logic role_valid;
  logic next_role_valid;
  logic [TW-1:0] toggle_cnt;
  logic [TW-1:0] next_toggle_cnt;
  logic orient_pos2;
  logic next_orient_pos2;
  logic [1:0] sink_level;
  logic [1:0] next_sink_level;
  logic [1:0] adv_level;
  logic oc_prev;
  logic fault_active;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] fault_cnt;
  logic [31:0] next_fault_cnt;
  logic force_detach;
  logic src_seen;
  logic snk_seen;
  logic apb_write;

  assign force_detach = ctrl[ccprs_pkg::CTRL_FORCE_DETACH];
  assign src_seen = s_rd1 | s_rd2;
  assign snk_seen = (s_adv1 != ccprs_pkg::CUR_NONE) | (s_adv2 != ccprs_pkg::CUR_NONE);
  assign apb_write = psel & penable & pready & pwrite;

  // ----------------------------------------------------------------
  // Strap decode for the advertised current
  // ----------------------------------------------------------------
  always_comb begin
    case (s_cur)
      ccprs_pkg::STRAP_MID: adv_level = ccprs_pkg::CUR_MEDIUM;
      ccprs_pkg::STRAP_HIGH: adv_level = ccprs_pkg::CUR_HIGH;
      default: adv_level = ccprs_pkg::CUR_DEFAULT;
    endcase
  end

  // ----------------------------------------------------------------
  // Role capture and attach state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_role = role;
    next_role_valid = role_valid;
    next_toggle_cnt = '0;
    next_orient_pos2 = orient_pos2;
    next_sink_level = sink_level;
    // Role is frozen after capture so a strap glitch cannot flip it
    if (!role_valid && s_supply) begin
      next_role_valid = 1'b1;
      case (s_role)
        ccprs_pkg::STRAP_HIGH: next_role = ccprs_pkg::ROLE_SOURCE;
        ccprs_pkg::STRAP_LOW: next_role = ccprs_pkg::ROLE_SINK;
        default: next_role = ccprs_pkg::ROLE_DUAL;
      endcase
    end
    case (state)
      ccprs_pkg::ST_WAIT_SUPPLY: begin
        if (role_valid) begin
          next_state = (role == ccprs_pkg::ROLE_SOURCE) ? ccprs_pkg::ST_UNATT_SRC : ccprs_pkg::ST_UNATT_SNK;
        end
      end
      ccprs_pkg::ST_UNATT_SNK: begin
        next_toggle_cnt = toggle_cnt + 1'b1;
        if (!force_detach && snk_seen && s_vbus) begin
          next_state = ccprs_pkg::ST_ATT_SNK;
          next_orient_pos2 = (s_adv1 == ccprs_pkg::CUR_NONE);
          next_sink_level = (s_adv1 != ccprs_pkg::CUR_NONE) ? s_adv1 : s_adv2;
        end else if (role == ccprs_pkg::ROLE_DUAL && toggle_cnt == TOGGLE_LAST) begin
          next_state = ccprs_pkg::ST_UNATT_SRC;
          next_toggle_cnt = '0;
        end
      end
      ccprs_pkg::ST_ATT_SNK: begin
        // Detach on loss of bus power; level follows the partner
        if (force_detach || !s_vbus) begin
          next_state = ccprs_pkg::ST_UNATT_SNK;
          next_sink_level = ccprs_pkg::CUR_NONE;
        end else begin
          next_sink_level = orient_pos2 ? s_adv2 : s_adv1;
        end
      end
      ccprs_pkg::ST_UNATT_SRC: begin
        next_toggle_cnt = toggle_cnt + 1'b1;
        if (!force_detach && src_seen) begin
          next_state = ccprs_pkg::ST_ATT_SRC;
          next_orient_pos2 = !s_rd1;
        end else if (role == ccprs_pkg::ROLE_DUAL && toggle_cnt == TOGGLE_LAST) begin
          next_state = ccprs_pkg::ST_UNATT_SNK;
          next_toggle_cnt = '0;
        end
      end
      ccprs_pkg::ST_ATT_SRC: begin
        if (force_detach || !(orient_pos2 ? s_rd2 : s_rd1)) begin
          next_state = ccprs_pkg::ST_UNATT_SRC;
        end
      end
      default: next_state = ccprs_pkg::ST_WAIT_SUPPLY;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ccprs_pkg::ST_WAIT_SUPPLY;
      role <= ccprs_pkg::ROLE_DUAL;
      role_valid <= 1'b0;
      toggle_cnt <= '0;
      orient_pos2 <= 1'b0;
      sink_level <= ccprs_pkg::CUR_NONE;
    end else begin
      state <= next_state;
      role <= next_role;
      role_valid <= next_role_valid;
      toggle_cnt <= next_toggle_cnt;
      orient_pos2 <= next_orient_pos2;
      sink_level <= next_sink_level;
    end
  end

  // ----------------------------------------------------------------
  // Cable supply fault pulse
  // ----------------------------------------------------------------
  ccprs_pulse_timer #(
    .COUNT(int'(FAULT_PULSE_CYCLES))
  ) u_fault (
    .pclk(pclk),
    .presetn(presetn),
    .start(s_oc & ~oc_prev),
    .active(fault_active)
  );

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic mapped;

  always_comb begin
    mapped = (paddr == ccprs_pkg::REG_CTRL) || (paddr == ccprs_pkg::REG_STATUS) ||
             (paddr == ccprs_pkg::REG_FAULT_CNT);
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ccprs_pkg::REG_CTRL: next_prdata = ctrl;
        ccprs_pkg::REG_STATUS: begin
          next_prdata[ccprs_pkg::STAT_STATE_LSB +: 3] = state;
          next_prdata[ccprs_pkg::STAT_ROLE_LSB +: 2] = role;
          next_prdata[ccprs_pkg::STAT_ORIENT] = orient_pos2;
          next_prdata[ccprs_pkg::STAT_LEVEL_LSB +: 2] = sink_level;
          next_prdata[ccprs_pkg::STAT_FAULT] = fault_active;
          next_prdata[ccprs_pkg::STAT_ROLE_VALID] = role_valid;
        end
        ccprs_pkg::REG_FAULT_CNT: next_prdata = fault_cnt;
        default: next_prdata = '0;
      endcase
    end
    next_ctrl = ctrl;
    if (apb_write && paddr == ccprs_pkg::REG_CTRL) begin
      next_ctrl = {31'h0000_0000, pwdata[ccprs_pkg::CTRL_FORCE_DETACH]};
    end
    // A write to the fault count register clears it, but a fault in that cycle still counts
    next_fault_cnt = fault_cnt;
    if (apb_write && paddr == ccprs_pkg::REG_FAULT_CNT) begin
      next_fault_cnt = '0;
    end
    if (s_oc && !oc_prev) begin
      next_fault_cnt = next_fault_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl <= ccprs_pkg::CTRL_RESET;
      fault_cnt <= '0;
      oc_prev <= 1'b0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      ctrl <= next_ctrl;
      fault_cnt <= next_fault_cnt;
      oc_prev <= s_oc;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive: open-drain outputs only ever pull low
  // ----------------------------------------------------------------
  logic next_pu_en;
  logic [1:0] next_pu_level;
  logic next_pd_en;
  logic next_ind_a_oe;
  logic next_ind_b_oe;
  logic next_attach_oe;
  logic next_orient_oe;
  logic next_fault_oe;
  logic sink_att;
  logic src_att;

  always_comb begin
    sink_att = (state == ccprs_pkg::ST_ATT_SNK);
    src_att = (state == ccprs_pkg::ST_ATT_SRC);
    next_pu_en = (state == ccprs_pkg::ST_UNATT_SRC) || src_att;
    next_pu_level = next_pu_en ? adv_level : ccprs_pkg::CUR_NONE;
    next_pd_en = (state == ccprs_pkg::ST_UNATT_SNK) || sink_att;
    // Sink indicators released when detached or not sinking
    next_ind_a_oe = sink_att && (sink_level == ccprs_pkg::CUR_MEDIUM ||
                                 sink_level == ccprs_pkg::CUR_HIGH);
    next_ind_b_oe = sink_att && (sink_level == ccprs_pkg::CUR_HIGH);
    next_attach_oe = src_att;
    next_orient_oe = (sink_att || src_att) && !orient_pos2;
    next_fault_oe = fault_active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_pullup_en <= 1'b0;
      cc_pullup_level <= ccprs_pkg::CUR_NONE;
      cc_pulldown_en <= 1'b0;
      sink_current_ind_a_oe <= 1'b0;
      sink_current_ind_b_oe <= 1'b0;
      source_attach_n_oe <= 1'b0;
      orient_oe <= 1'b0;
      cable_supply_fault_n_oe <= 1'b0;
      sink_current_ind_a_o <= 1'b0;
      sink_current_ind_b_o <= 1'b0;
      source_attach_n_o <= 1'b0;
      orient_o <= 1'b0;
      cable_supply_fault_n_o <= 1'b0;
    end else begin
      cc_pullup_en <= next_pu_en;
      cc_pullup_level <= next_pu_level;
      cc_pulldown_en <= next_pd_en;
      sink_current_ind_a_oe <= next_ind_a_oe;
      sink_current_ind_b_oe <= next_ind_b_oe;
      source_attach_n_oe <= next_attach_oe;
      orient_oe <= next_orient_oe;
      cable_supply_fault_n_oe <= next_fault_oe;
      sink_current_ind_a_o <= 1'b0;
      sink_current_ind_b_o <= 1'b0;
      source_attach_n_o <= 1'b0;
      orient_o <= 1'b0;
      cable_supply_fault_n_o <= 1'b0;
    end
  end

endmodule : ccprs_port_ctrl

// >>> verilog/ccprs_pulse_timer.sv
`timescale 1ns/1ps
module ccprs_pulse_timer #(
  parameter int unsigned COUNT = 200000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic active
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_active;

  // ----------------------------------------------------------------
  // One-shot of exactly COUNT cycles; retrigger while busy is ignored
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_active = active;
    if (active) begin
      if (cnt == LAST) begin
        next_active = 1'b0;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end else if (start) begin
      next_active = 1'b1;
      next_cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      active <= 1'b0;
    end else begin
      cnt <= next_cnt;
      active <= next_active;
    end
  end

endmodule : ccprs_pulse_timer

// >>> verilog/ccprs_sync.sv
`timescale 1ns/1ps
module ccprs_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ccprs_pkg::SYNC_WIDTH-1:0] async_in,
  output logic [ccprs_pkg::SYNC_WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Three-stage synchroniser with agreement filter per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ccprs_pkg::SYNC_WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic next_out;
      // A change is taken only once stages two and three agree
      always_comb begin
        next_out = (s2 == s3) ? s3 : sync_out[i];
      end
      // First stage feeds nothing but the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1 <= async_in[i];
          s2 <= s1;
          s3 <= s2;
          sync_out[i] <= next_out;
        end
      end
    end
  endgenerate

endmodule : ccprs_sync
